// file: wdc_pkg.sv
// Package: constants for the watchdog downcounter
package wdc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DECR_CYCLES = 3072;
  localparam int unsigned PSC_W = 12;
  localparam logic [PSC_W-1:0] PSC_LAST = 12'(DECR_CYCLES - 1);
  localparam int unsigned RST_PULSE_NS = 500;
  // Longest time: round down, at least one cycle
  localparam int unsigned RST_PULSE_CYC_RAW = (RST_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_CYC_RAW < 1) ? 1 : RST_PULSE_CYC_RAW;
  localparam int unsigned PULSE_W = 4;
  localparam logic [PULSE_W-1:0] PULSE_LAST = 4'(RST_PULSE_CYC - 1);
  localparam logic [7:0] REG_RESET = 8'hFE;
  localparam int unsigned BIT_ACT = 0;
  localparam int unsigned BIT_SOFT = 1;
  localparam int unsigned CNT_W = 7;
  typedef enum logic [2:0] {
    WDC_RUN = 3'b001,
    WDC_FROZEN = 3'b010,
    WDC_PULSE = 3'b100
  } wdc_state_t;
endpackage

// file: wdc_bitrev.sv
// Maps the counter to register bit order
module wdc_bitrev (
  input wire logic [6:0] cnt,
  output logic [7:1] reg_bits
);
  always_comb begin
    reg_bits[1] = cnt[6];
    for (int i = 0; i < 6; i++) begin
      reg_bits[7 - i] = cnt[i];
    end
  end
endmodule // wdc_bitrev

// file: wdc_watchdog.sv
// Watchdog downcounter with reset pulse and stop-mode gating
// Notes on behaviour
// RL1: Hardware option: always active, activate bit forced.
// RL2: Hardware option: activate bit read unreliable.
// RL3: Software option: set once, stays until reset.
// RL4: Seven-bit counter decrements every 3072 cycles.
// RL5: Timeout set in 64 steps by count bits.
// RL6: Active and soft bit clear: reset pulse low.
// RL7: Writing soft bit clear while active resets.
// RL8: Software reloads FEh..02h before expiry.
// RL9: Reload writes soft bit one, wanted count.
// RL10: Inactive software option: plain reversed 7-bit timer.
// RL11: Timer readers read twice and compare.
// RL12: Wait leaves counter and activation untouched.
// RL13: Watchdog disabled: stop enters stop mode.
// RL14: Enabled, no external control: stop acts as wait.
// RL15: External control: NMI high freezes and stops.
// RL16: Leaving stop resumes from held count.
// RL17: Bit 7 LSB, bit 2 MSB, soft, activate.
// RL18: Register resets to FEh.
// RL19: Watchdog reset restores register reset value.
module wdc_watchdog (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HW_ACTIVATION_OPTION,
  input wire logic EXTERNAL_STOP_CONTROL_OPTION,
  input wire logic NMI_PIN,
  input wire logic WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic STOP_INSTR,
  input wire logic WAKE_INTERRUPT,
  output logic [7:0] RD_DATA,
  output logic RESET_PIN_N,
  output logic RESET_PIN_OE_N,
  output logic ENTER_STOP,
  output logic ENTER_WAIT,
  output logic WATCHDOG_ACTIVE
);
  import wdc_pkg::*;

  logic nmi_meta, nmi_sync;
  logic hw_meta, ext_meta;
  logic hw_opt, ext_opt;
  logic [CNT_W-1:0] rst_cnt;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic act, next_act;
  logic [PSC_W-1:0] psc, next_psc;
  logic [PULSE_W-1:0] pls, next_pls;
  wdc_state_t state, next_state;
  logic [7:1] cnt_reg_bits;
  logic [CNT_W-1:0] wr_cnt;
  logic active, expire, stop_req, wait_req;

  // Option straps and NMI are off-domain levels
  always_ff @(posedge CLK) begin
    nmi_meta <= NMI_PIN;
    nmi_sync <= nmi_meta;
  end

  // Option straps resampled each clock through two flops, like the NMI pin
  always_ff @(posedge CLK) begin
    hw_meta <= HW_ACTIVATION_OPTION;
    ext_meta <= EXTERNAL_STOP_CONTROL_OPTION;
    hw_opt <= hw_meta;
    ext_opt <= ext_meta;
  end

  assign active = hw_opt | act; // RL1 RL3

  // Written bits back to counter order
  always_comb begin
    wr_cnt[6] = WR_DATA[BIT_SOFT]; // RL17
    for (int i = 0; i < 6; i++) begin
      wr_cnt[i] = WR_DATA[7 - i]; // RL17
    end
  end

  // Reset image back to counter order, so the reset value lives in one place
  always_comb begin
    rst_cnt[CNT_W-1] = REG_RESET[BIT_SOFT];
    for (int i = 0; i < CNT_W - 1; i++) begin
      rst_cnt[i] = REG_RESET[7 - i];
    end
  end

  wdc_bitrev u_rev (
    .cnt(cnt),
    .reg_bits(cnt_reg_bits)
  );

  assign stop_req = STOP_INSTR && state == WDC_RUN;
  // Stop only when watchdog off, or external control with NMI high
  always_comb begin
    ENTER_STOP = 1'b0;
    ENTER_WAIT = 1'b0;
    if (stop_req) begin
      if (!active) begin
        ENTER_STOP = 1'b1; // RL13
      end else if (ext_opt && nmi_sync) begin
        ENTER_STOP = 1'b1; // RL15
      end else begin
        ENTER_WAIT = 1'b1; // RL14 RL15
      end
    end
  end
  assign wait_req = ENTER_WAIT; // RL12

  assign expire = active && !cnt[CNT_W-1];

  always_comb begin
    next_cnt = cnt;
    next_act = act;
    next_psc = psc;
    next_pls = pls;
    next_state = state;
    case (state)
      WDC_RUN: begin
        if (psc == PSC_LAST) begin
          next_psc = '0;
          next_cnt = cnt - 7'h01; // RL4 RL5 RL10
        end else begin
          next_psc = psc + 12'h001;
        end
        if (WR_EN) begin
          next_cnt = wr_cnt; // RL5
          next_act = act | WR_DATA[BIT_ACT]; // RL3
        end
        if (expire || (WR_EN && active && !WR_DATA[BIT_SOFT])) begin
          next_state = WDC_PULSE; // RL6 RL7
          next_pls = '0;
        end else if (ENTER_STOP && active) begin
          next_state = WDC_FROZEN; // RL15
        end
      end
      WDC_FROZEN: begin
        if (WAKE_INTERRUPT) begin
          next_state = WDC_RUN; // RL16
        end
      end
      WDC_PULSE: begin
        if (pls == PULSE_LAST) begin
          next_state = WDC_RUN;
          next_cnt = rst_cnt; // RL19
          next_act = 1'b0; // RL19
          next_psc = '0;
        end else begin
          next_pls = pls + 4'h1;
        end
      end
      default: begin
        next_state = WDC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt <= rst_cnt; // RL18
      act <= REG_RESET[BIT_ACT]; // RL18
      psc <= '0;
      pls <= '0;
      state <= WDC_RUN;
    end else begin
      cnt <= next_cnt;
      act <= next_act;
      psc <= next_psc;
      pls <= next_pls;
      state <= next_state;
    end
  end

  // Activate bit reads the stored flag; under hardware option it may read 0
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RD_DATA <= REG_RESET;
      RESET_PIN_N <= 1'b1;
      RESET_PIN_OE_N <= 1'b1;
      WATCHDOG_ACTIVE <= 1'b0;
    end else begin
      RD_DATA <= {cnt_reg_bits, act}; // RL2 RL17
      RESET_PIN_N <= next_state != WDC_PULSE; // RL6
      RESET_PIN_OE_N <= next_state != WDC_PULSE;
      WATCHDOG_ACTIVE <= active;
    end
  end

  a_expire_pulse: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_RUN && expire) |=> (state == WDC_PULSE)) // RL6
    else $error("expiry did not start reset pulse");
  a_soft_write: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_RUN && WR_EN && active && !WR_DATA[BIT_SOFT]) |=> state == WDC_PULSE) // RL7
    else $error("soft reset write ignored");
  a_act_sticky: assert property (@(posedge CLK) disable iff (RESET)
    (act && state != WDC_PULSE) |=> act) // RL3
    else $error("activate bit dropped");
  a_pin_low: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_PULSE) |-> (!RESET_PIN_N && !RESET_PIN_OE_N)) // RL6
    else $error("reset pin not driven");
  a_decrement: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_RUN && psc == PSC_LAST && !WR_EN && !expire) |=> cnt == $past(cnt) - 7'h01) // RL4
    else $error("counter did not decrement");
  a_frozen_hold: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_FROZEN) |=> $stable(cnt)) // RL15
    else $error("frozen counter moved");
  a_stop_wait: assert property (@(posedge CLK) disable iff (RESET)
    (stop_req && active && !ext_opt) |-> (ENTER_WAIT && !ENTER_STOP)) // RL14
    else $error("stop not turned into wait");
  a_stop_off: assert property (@(posedge CLK) disable iff (RESET)
    (stop_req && !active) |-> ENTER_STOP) // RL13
    else $error("stop refused with watchdog off");
  a_wait_keep: assert property (@(posedge CLK) disable iff (RESET) // RL12
    (wait_req && !WR_EN && !expire) |=> (state == WDC_RUN && act == $past(act)))
    else $error("wait disturbed the watchdog");
  a_frozen_psc: assert property (@(posedge CLK) disable iff (RESET) // RL16
    (state == WDC_FROZEN) |=> $stable(psc))
    else $error("frozen prescaler moved");
  a_reset_image: assert property (@(posedge CLK) // RL18
    $past(RESET) |-> (RD_DATA == REG_RESET && RESET_PIN_N && RESET_PIN_OE_N))
    else $error("register image wrong after reset");
  a_pulse_end: assert property (@(posedge CLK) disable iff (RESET)
    (state == WDC_PULSE && pls == PULSE_LAST) |=> (cnt == 7'h7F && !act)) // RL19
    else $error("register not restored after reset");
  c_expiry: cover property (@(posedge CLK) state == WDC_RUN && expire);
  c_soft: cover property (@(posedge CLK) WR_EN && active && !WR_DATA[BIT_SOFT]);
  c_frozen: cover property (@(posedge CLK) state == WDC_FROZEN ##1 state == WDC_RUN);
  c_wait: cover property (@(posedge CLK) ENTER_WAIT);
  c_pulse_end: cover property (@(posedge CLK) state == WDC_PULSE && pls == PULSE_LAST);
endmodule // wdc_watchdog

// file: wdc_testbench.sv
// Self-checking testbench for the watchdog downcounter
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hw, ext, nmi, wr_en, stop, wake;
  logic [7:0] wr_data, rd;
  logic pin_n, oe_n, e_stop, e_wait, act;
  int n_mismatch = 0, checked = 0, cyc = 0, lows = 0, w;

  wdc_watchdog dut (.CLK(clk), .RESET(rst), .HW_ACTIVATION_OPTION(hw),
    .EXTERNAL_STOP_CONTROL_OPTION(ext), .NMI_PIN(nmi), .WR_EN(wr_en),
    .WR_DATA(wr_data), .STOP_INSTR(stop), .WAKE_INTERRUPT(wake), .RD_DATA(rd),
    .RESET_PIN_N(pin_n), .RESET_PIN_OE_N(oe_n), .ENTER_STOP(e_stop),
    .ENTER_WAIT(e_wait), .WATCHDOG_ACTIVE(act));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Counts cycles with the reset pin driven low; also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (pin_n === 1'b0 && oe_n === 1'b0) lows++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
  endtask

  // Register shows the write one edge after it is taken
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic waitc(input int lim);
    logic [7:0] v;
    v = rd;
    w = 0;
    while (rd === v && w < lim) begin
      @(posedge clk);
      #1;
      w++;
    end
  endtask

  // Stop request decode is combinational, looked at mid-cycle
  task automatic stp(input logic es, input logic ew);
    @(posedge clk);
    stop <= 1;
    @(negedge clk);
    chk("enter_stop", {7'h0, es}, {7'h0, e_stop});
    chk("enter_wait", {7'h0, ew}, {7'h0, e_wait});
    @(posedge clk);
    stop <= 0;
  endtask

  task automatic pulse_wake();
    @(posedge clk);
    wake <= 1;
    @(posedge clk);
    wake <= 0;
  endtask

  task automatic t_timer();
    logic [7:0] v;
    chk("reset value", 8'hFE, rd);
    chk("active", 8'h00, {7'h0, act});
    waitc(3100);
    chk("decrement period", 8'h01, {7'h0, w > 3060 && w < 3080});
    chk("first decrement", 8'h7E, rd);
    v = rd;
    @(posedge clk);
    #1;
    chk("second read", v, rd);
    lows = 0;
    wr(8'h02);
    waitc(3100);
    chk("timer wrap", 8'hFC, rd);
    chk("pulse while inactive", 8'h00, lows[7:0]);
    $display("timer test done");
  endtask

  task automatic t_activate();
    wr(8'hFF);
    chk("activated", 8'h01, {7'h0, act});
    wr(8'hFE);
    chk("stays active", 8'h01, {7'h0, act});
    lows = 0;
    wr(8'hFD);
    repeat (8) @(posedge clk);
    #1;
    chk("soft reset cycles", 8'h05, lows[7:0]);
    chk("after reset", 8'hFE, rd);
    chk("deactivated", 8'h00, {7'h0, act});
    wr(8'h03);
    lows = 0;
    w = 0;
    while (lows == 0 && w < 3200) begin
      @(posedge clk);
      w++;
    end
    chk("expiry delay", 8'h01, {7'h0, w > 3040 && w < 3090});
    repeat (8) @(posedge clk);
    #1;
    chk("expiry cycles", 8'h05, lows[7:0]);
    chk("after expiry", 8'hFE, rd);
    $display("activation test done");
  endtask

  task automatic t_stop();
    logic [7:0] v;
    hw <= 1;
    do_reset();
    chk("hw active", 8'h01, {7'h0, act});
    wr(8'hFE);
    chk("hw forced", 8'h01, {7'h0, act});
    stp(1'b0, 1'b1);
    chk("active after wait", 8'h01, {7'h0, act});
    ext <= 1;
    repeat (3) @(posedge clk);
    stp(1'b0, 1'b1);
    nmi <= 1;
    repeat (3) @(posedge clk);
    stp(1'b1, 1'b0);
    @(posedge clk);
    #1;
    v = rd;
    repeat (3200) @(posedge clk);
    #1;
    chk("frozen count", v, rd);
    pulse_wake();
    waitc(3100);
    chk("resumed", 8'h01, {7'h0, w < 3100});
    hw <= 0;
    ext <= 0;
    do_reset();
    stp(1'b1, 1'b0);
    pulse_wake();
    $display("stop test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {rst, hw, ext, nmi, wr_en, stop, wake} = 7'h40;
    wr_data = 8'h00;
    do_reset();
    t_timer();
    t_activate();
    t_stop();
    tally_and_finish();
  end
endmodule // testbench
